// *** rtl/ecb_pkg.sv ***
// Purpose: constants for the extended configuration header bank
// Assumes: dword-addressed configuration requests, 12-bit byte offsets
// Notes: reset classes cover sticky, link-reset and hot-reset bits
// Operation
// - sticky bits clear only on global reset or power-on reset.
// - link-class bits clear on link, global or power-on reset, not hot reset.
// - all other bits also clear on hot reset.
// - capability identifier at 100h reads 0001h, read-only, writes ignored.
// - enable bit low makes next-pointer field read 000h.
// - enable bit high makes next-pointer field read 150h.
// - low four bits of 102h always read version 1h.
// - 102h is read-only; pointer derived combinationally from enable bit.
package ecb_pkg;
   localparam logic [11:0] ECB_OFF_CAP_HDR = 12'h100;
   localparam logic [11:0] ECB_OFF_FATAL_FLAGS = 12'h104;
   localparam logic [11:0] ECB_OFF_FATAL_SUPPRESS = 12'h108;
   localparam logic [11:0] ECB_OFF_FATAL_CLASS_SEL = 12'h10C;
   localparam logic [11:0] ECB_OFF_SOFT_FLAGS = 12'h110;
   localparam logic [11:0] ECB_OFF_SOFT_SUPPRESS = 12'h114;
   localparam logic [11:0] ECB_OFF_ERR_CONTROL = 12'h118;
   localparam logic [11:0] ECB_OFF_FAULT_HDR0 = 12'h11C;
   localparam logic [11:0] ECB_OFF_FAULT_HDR1 = 12'h120;
   localparam logic [11:0] ECB_OFF_FAULT_HDR2 = 12'h124;
   localparam logic [11:0] ECB_OFF_FAULT_HDR3 = 12'h128;
   localparam logic [11:0] ECB_OFF_DS_FATAL_FLAGS = 12'h12C;
   localparam logic [11:0] ECB_OFF_DS_FATAL_SUPPRESS = 12'h130;
   localparam logic [11:0] ECB_OFF_DS_FATAL_CLASS = 12'h134;
   localparam logic [11:0] ECB_OFF_DS_ERR_CONTROL = 12'h138;
   localparam logic [11:0] ECB_OFF_DS_HDR0 = 12'h13C;
   localparam logic [11:0] ECB_OFF_DS_HDR1 = 12'h140;
   localparam logic [11:0] ECB_OFF_DS_HDR2 = 12'h144;
   localparam logic [11:0] ECB_OFF_DS_HDR3 = 12'h148;
   localparam logic [11:0] ECB_OFF_CHAN_CAP_HDR = 12'h150;
   localparam logic [11:0] ECB_OFF_PORT_CHAN_CAP1 = 12'h154;
   localparam logic [11:0] ECB_OFF_PORT_CHAN_CAP2 = 12'h158;
   localparam logic [11:0] ECB_OFF_PORT_CHAN_CTRL_STAT = 12'h15C;
   localparam logic [11:0] ECB_OFF_CHAN0_RES_CAP = 12'h160;
   localparam logic [11:0] ECB_OFF_CHAN0_RES_CTRL = 12'h164;
   localparam logic [11:0] ECB_OFF_CHAN0_RES_STAT = 12'h168;
   localparam logic [11:0] ECB_OFF_CHAN1_RES_CAP = 12'h16C;
   localparam logic [11:0] ECB_OFF_CHAN1_RES_CTRL = 12'h170;
   localparam logic [11:0] ECB_OFF_CHAN_ARB_0 = 12'h180;
   localparam logic [11:0] ECB_OFF_CHAN_ARB_2 = 12'h188;
   localparam logic [11:0] ECB_OFF_CHAN_ARB_3 = 12'h18C;
   localparam logic [11:0] ECB_OFF_PORT_ARB_0 = 12'h1C0;
   localparam logic [11:0] ECB_OFF_PORT_ARB_1 = 12'h1C4;
   localparam logic [11:0] ECB_OFF_PORT_ARB_2 = 12'h1C8;
   localparam logic [11:0] ECB_OFF_PORT_ARB_3 = 12'h1CC;
   localparam logic [11:0] ECB_OFF_PORT_ARB_4 = 12'h1D0;
   localparam logic [11:0] ECB_OFF_PORT_ARB_5 = 12'h1D4;
   localparam logic [11:0] ECB_OFF_PORT_ARB_6 = 12'h1D8;
   localparam logic [11:0] ECB_OFF_PORT_ARB_7 = 12'h1DC;
   localparam logic [11:0] ECB_OFF_PORT_ARB_8 = 12'h1E0;
   localparam logic [11:0] ECB_OFF_PORT_ARB_9 = 12'h1E4;
   localparam logic [11:0] ECB_OFF_PORT_ARB_10 = 12'h1E8;
   localparam logic [11:0] ECB_OFF_PORT_ARB_11 = 12'h1EC;
   localparam logic [11:0] ECB_OFF_PORT_ARB_12 = 12'h1F0;
   localparam logic [11:0] ECB_OFF_PORT_ARB_13 = 12'h1F4;
   localparam logic [11:0] ECB_OFF_PORT_ARB_14 = 12'h1F8;
   localparam logic [11:0] ECB_OFF_PORT_ARB_15 = 12'h1FC;
   localparam logic [15:0] ECB_ERR_CAP_ID = 16'h0001;
   localparam logic [11:0] ECB_NEXT_VC = 12'h150;
   localparam logic [11:0] ECB_NEXT_END = 12'h000;
   localparam logic [3:0] ECB_CAP_VERSION = 4'h1;
   localparam int ECB_NUM_WORDS = 64;
   localparam logic [31:0] ECB_WORD_RESET = 32'h0000_0000;
   typedef enum logic [1:0] {ECB_CLASS_HOT, ECB_CLASS_LINK, ECB_CLASS_STICKY} ecb_class_e;
endpackage : ecb_pkg

// *** rtl/ecb_header_bank.sv ***
// Purpose: extended configuration header bank with three reset classes
// Purpose: header word decode, storage words, reserved-offset handling
// Assumes: one request per cycle, read data one cycle after the request
// Assumes: offsets are byte offsets; the low two address bits are ignored
// Notes: per-word reset class is chosen by module parameters
// Notes: resets win over a write in the same cycle
`timescale 1ns/1ps
`default_nettype none
module ecb_header_bank
   import ecb_pkg::*;
#(
   parameter logic [ECB_NUM_WORDS-1:0] STICKY_MAP = '0,
   parameter logic [ECB_NUM_WORDS-1:0] LINK_MAP = {ECB_NUM_WORDS{1'b1}}
)
(
   // clock
   input wire logic ref_clk,

   // power-on and global resets
   input wire logic srst,
   input wire logic global_reset_input,

   // link-side resets
   input wire logic link_reset,
   input wire logic hot_reset,

   // general control
   input wire logic channel_capability_enable,

   // request strobes
   input wire logic cfg_rd,
   input wire logic cfg_wr,

   // address, lanes and data
   input wire logic [11:0] cfg_addr,
   input wire logic [3:0] cfg_be,
   input wire logic [31:0] cfg_wdata,

   // configuration answer
   output logic [31:0] cfg_rdata,
   output logic cfg_rvalid
);

   // =======================================================
   // state
   typedef struct packed
   {
      logic [ECB_NUM_WORDS-1:0][31:0] word;
      logic [31:0] rdata;
      logic rvalid;
   } ecb_state_s;

   ecb_state_s st;
   ecb_state_s next_st;

   // =======================================================
   // address decode: error reporting registers
   function automatic logic in_error_block(input logic [11:0] a);
      case (a)
         // upstream flags and controls
         ECB_OFF_FATAL_FLAGS:
            in_error_block = 1'b1;
         ECB_OFF_FATAL_SUPPRESS:
            in_error_block = 1'b1;
         ECB_OFF_FATAL_CLASS_SEL:
            in_error_block = 1'b1;
         ECB_OFF_SOFT_FLAGS:
            in_error_block = 1'b1;
         ECB_OFF_SOFT_SUPPRESS:
            in_error_block = 1'b1;
         ECB_OFF_ERR_CONTROL:
            in_error_block = 1'b1;

         // upstream fault header log
         ECB_OFF_FAULT_HDR0:
            in_error_block = 1'b1;
         ECB_OFF_FAULT_HDR1:
            in_error_block = 1'b1;
         ECB_OFF_FAULT_HDR2:
            in_error_block = 1'b1;
         ECB_OFF_FAULT_HDR3:
            in_error_block = 1'b1;

         // downstream flags and controls
         ECB_OFF_DS_FATAL_FLAGS:
            in_error_block = 1'b1;
         ECB_OFF_DS_FATAL_SUPPRESS:
            in_error_block = 1'b1;
         ECB_OFF_DS_FATAL_CLASS:
            in_error_block = 1'b1;
         ECB_OFF_DS_ERR_CONTROL:
            in_error_block = 1'b1;

         // downstream fault header log
         ECB_OFF_DS_HDR0:
            in_error_block = 1'b1;
         ECB_OFF_DS_HDR1:
            in_error_block = 1'b1;
         ECB_OFF_DS_HDR2:
            in_error_block = 1'b1;
         ECB_OFF_DS_HDR3:
            in_error_block = 1'b1;

         default:
            in_error_block = 1'b0;
      endcase
   endfunction : in_error_block

   // =======================================================
   // address decode: channel capability registers
   function automatic logic in_channel_block(input logic [11:0] a);
      case (a)
         // capability and port control
         ECB_OFF_CHAN_CAP_HDR:
            in_channel_block = 1'b1;
         ECB_OFF_PORT_CHAN_CAP1:
            in_channel_block = 1'b1;
         ECB_OFF_PORT_CHAN_CAP2:
            in_channel_block = 1'b1;
         ECB_OFF_PORT_CHAN_CTRL_STAT:
            in_channel_block = 1'b1;

         // per-channel resources
         ECB_OFF_CHAN0_RES_CAP:
            in_channel_block = 1'b1;
         ECB_OFF_CHAN0_RES_CTRL:
            in_channel_block = 1'b1;
         ECB_OFF_CHAN0_RES_STAT:
            in_channel_block = 1'b1;
         ECB_OFF_CHAN1_RES_CAP:
            in_channel_block = 1'b1;
         ECB_OFF_CHAN1_RES_CTRL:
            in_channel_block = 1'b1;

         default:
            in_channel_block = 1'b0;
      endcase
   endfunction : in_channel_block

   // =======================================================
   // address decode: channel arbitration table
   function automatic logic in_channel_arb(input logic [11:0] a);
      case (a)
         ECB_OFF_CHAN_ARB_0:
            in_channel_arb = 1'b1;
         ECB_OFF_CHAN_ARB_2:
            in_channel_arb = 1'b1;
         ECB_OFF_CHAN_ARB_3:
            in_channel_arb = 1'b1;

         default:
            in_channel_arb = 1'b0;
      endcase
   endfunction : in_channel_arb

   // =======================================================
   // address decode: port arbitration table
   function automatic logic in_port_arb(input logic [11:0] a);
      case (a)
         // phases 0 to 63
         ECB_OFF_PORT_ARB_0:
            in_port_arb = 1'b1;
         ECB_OFF_PORT_ARB_1:
            in_port_arb = 1'b1;
         ECB_OFF_PORT_ARB_2:
            in_port_arb = 1'b1;
         ECB_OFF_PORT_ARB_3:
            in_port_arb = 1'b1;
         ECB_OFF_PORT_ARB_4:
            in_port_arb = 1'b1;
         ECB_OFF_PORT_ARB_5:
            in_port_arb = 1'b1;
         ECB_OFF_PORT_ARB_6:
            in_port_arb = 1'b1;
         ECB_OFF_PORT_ARB_7:
            in_port_arb = 1'b1;

         // phases 64 to 127
         ECB_OFF_PORT_ARB_8:
            in_port_arb = 1'b1;
         ECB_OFF_PORT_ARB_9:
            in_port_arb = 1'b1;
         ECB_OFF_PORT_ARB_10:
            in_port_arb = 1'b1;
         ECB_OFF_PORT_ARB_11:
            in_port_arb = 1'b1;
         ECB_OFF_PORT_ARB_12:
            in_port_arb = 1'b1;
         ECB_OFF_PORT_ARB_13:
            in_port_arb = 1'b1;
         ECB_OFF_PORT_ARB_14:
            in_port_arb = 1'b1;
         ECB_OFF_PORT_ARB_15:
            in_port_arb = 1'b1;

         default:
            in_port_arb = 1'b0;
      endcase
   endfunction : in_port_arb

   // =======================================================
   // address decode: storage map; the header word and the gaps are not storage
   function automatic logic is_storage(input logic [11:0] a);
      is_storage = in_error_block(a)
         || in_channel_block(a)
         || in_channel_arb(a)
         || in_port_arb(a);
   endfunction : is_storage

   // the header word is computed, never stored
   function automatic logic is_header(input logic [11:0] a);
      is_header = (a == ECB_OFF_CAP_HDR);
   endfunction : is_header

   // word 0 would be the header word and stays unused
   function automatic logic [5:0] word_index(input logic [11:0] a);
      word_index = a[7:2];
   endfunction : word_index

   // =======================================================
   // reset classes
   function automatic ecb_class_e word_class(input int i);
      if (STICKY_MAP[i])
      begin
         word_class = ECB_CLASS_STICKY;
      end
      else if (LINK_MAP[i])
      begin
         word_class = ECB_CLASS_LINK;
      end
      else
      begin
         word_class = ECB_CLASS_HOT;
      end
   endfunction : word_class

   // true when a link-side reset wipes a word of the given class
   function automatic logic class_clears(input ecb_class_e c, input logic lnk, input logic hot);
      case (c)
         ECB_CLASS_STICKY:
         begin
            class_clears = 1'b0;
         end
         ECB_CLASS_LINK:
         begin
            class_clears = lnk;
         end
         ECB_CLASS_HOT:
         begin
            class_clears = lnk || hot;
         end
         default:
         begin
            class_clears = 1'b0;
         end
      endcase
   endfunction : class_clears

   // =======================================================
   // header word: read-only, pointer follows the enable bit directly
   function automatic logic [31:0] header_word(input logic enable);
      logic [11:0] next_ptr;
      if (enable)
      begin
         next_ptr = ECB_NEXT_VC;
      end
      else
      begin
         next_ptr = ECB_NEXT_END;
      end
      header_word = {next_ptr, ECB_CAP_VERSION, ECB_ERR_CAP_ID};
   endfunction : header_word

   // =======================================================
   // byte-lane handling for writes
   function automatic logic [31:0] lane_mask(input logic [3:0] lanes);
      logic [31:0] mask;
      mask = '0;
      for (int b = 0; b < 4; b++)
      begin
         if (lanes[b])
         begin
            mask[b*8 +: 8] = 8'hFF;
         end
      end
      lane_mask = mask;
   endfunction : lane_mask

   function automatic logic [31:0] merge_bytes(
      input logic [31:0] old_word,
      input logic [31:0] new_word,
      input logic [3:0] lanes
   );
      merge_bytes = (old_word & ~lane_mask(lanes)) | (new_word & lane_mask(lanes));
   endfunction : merge_bytes

   // =======================================================
   // read mux; anything but the header and storage reads zero
   function automatic logic [31:0] read_word(
      input ecb_state_s s,
      input logic [11:0] a,
      input logic enable
   );
      if (is_header(a))
      begin
         read_word = header_word(enable);
      end
      else if (is_storage(a))
      begin
         read_word = s.word[word_index(a)];
      end
      else
      begin
         read_word = '0;
      end
   endfunction : read_word

   // =======================================================
   // next state
   always_comb
   begin
      logic [11:0] a;
      a = {cfg_addr[11:2], 2'b00};
      next_st = st;

      // =======================================================
      // read answer stands for one cycle
      next_st.rvalid = cfg_rd;
      if (cfg_rd)
      begin
         next_st.rdata = read_word(st, a, channel_capability_enable);
      end
      else
      begin
         next_st.rdata = '0;
      end

      // =======================================================
      // writes land only in storage; header and gaps ignore them
      if (cfg_wr && is_storage(a))
      begin
         next_st.word[word_index(a)] =
            merge_bytes(st.word[word_index(a)], cfg_wdata, cfg_be);
      end

      // =======================================================
      // link and hot resets clear storage per class, after any write
      for (int i = 0; i < ECB_NUM_WORDS; i++)
      begin
         if (class_clears(word_class(i), link_reset, hot_reset))
         begin
            next_st.word[i] = ECB_WORD_RESET;
         end
      end
   end

   // =======================================================
   // registers; srst is the power-on reset
   always_ff @(posedge ref_clk)
   begin
      // power-on and global reset clear every class
      if (srst || global_reset_input)
      begin
         st.word <= '0;
         st.rdata <= '0;
         st.rvalid <= 1'b0;
      end
      else
      begin
         st <= next_st;
      end
   end

   // =======================================================
   // outputs
   assign cfg_rdata = st.rdata;
   assign cfg_rvalid = st.rvalid;
endmodule : ecb_header_bank
`default_nettype wire

// *** bench/ecb_host.sv ***
// Purpose: configuration host model; Assumes: full lanes; Notes: one request per call
`timescale 1ns/1ps
`default_nettype none
module ecb_host(
   // request
   input wire logic clk,
   output logic rd, wr,
   output logic [11:0] a,
   output logic [31:0] wd,
   // answer
   input wire logic [31:0] rdat,
   input wire logic rv
);
   initial {rd, wr, a, wd} = '0;
   task w(input logic [11:0] ad, input logic [31:0] d);
      @(posedge clk) {wr, a, wd} <= {1'b1, ad, d};
      @(posedge clk) {wr, a} <= {1'b0, ~ad};
   endtask : w
   // answer stands for the cycle after the taking edge; sample it at the next rising edge
   task r(input logic [11:0] ad, output logic [31:0] d, output logic v);
      @(posedge clk) {rd, a} <= {1'b1, ad};
      @(posedge clk) {rd, a} <= {1'b0, ~ad};
      @(posedge clk);
      d = rdat;
      v = rv;
   endtask : r
endmodule : ecb_host
`default_nettype wire

// *** bench/ecb_header_bank_checker.sv ***
// Purpose: port checks; Assumes: top ports only; Notes: bound at foot
`timescale 1ns/1ps
`default_nettype none
module ecb_header_bank_checker(
   // watched ports
   input wire logic ref_clk, srst, channel_capability_enable, cfg_rd, cfg_rvalid,
   input wire logic [11:0] cfg_addr,
   input wire logic [31:0] cfg_rdata
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (srst);
   a_read_answer: assert property (cfg_rd |=> cfg_rvalid) else $error("no answer");
   a_stray_answer: assert property (cfg_rvalid |-> $past(cfg_rd)) else $error("stray answer");
   a_list_end: assert property (
      cfg_rd && cfg_addr[11:2] == 10'h040 && !channel_capability_enable |=>
      cfg_rdata == 32'h0001_0001) else $error("end of list");
   a_list_link: assert property (
      cfg_rd && cfg_addr[11:2] == 10'h040 && channel_capability_enable |=>
      cfg_rdata == 32'h1501_0001) else $error("link pointer");
   a_gap_zero: assert property (
      cfg_rd && cfg_addr[11:2] == 10'h053 |=> cfg_rdata == 0) else $error("gap not zero");
   a_idle_zero: assert property (!cfg_rvalid |-> cfg_rdata == 0) else $error("idle data");
endmodule : ecb_header_bank_checker
bind ecb_header_bank ecb_header_bank_checker i_chk(.ref_clk, .srst,
   .channel_capability_enable, .cfg_rd, .cfg_rvalid, .cfg_addr, .cfg_rdata);
`default_nettype wire

// *** bench/tb.sv ***
// Purpose: bench; Assumes: 104h sticky, 108h link class; Notes: rest hot class
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic clk = 0, srst = 1, gr = 0, lr = 0, hr = 0, en = 0, rd, wr, rv;
   logic [11:0] a;
   logic [31:0] wd, rdat, d;
   int n_mismatch = 0, n_compared = 0;
   always #10 clk = ~clk;
   ecb_header_bank #(.STICKY_MAP(64'h2), .LINK_MAP(64'h4)) i_dut(.ref_clk(clk), .srst,
      .global_reset_input(gr), .link_reset(lr), .hot_reset(hr), .channel_capability_enable(en),
      .cfg_rd(rd), .cfg_wr(wr), .cfg_addr(a), .cfg_be(4'hF), .cfg_wdata(wd), .cfg_rdata(rdat),
      .cfg_rvalid(rv));
   ecb_host i_host(.clk, .rd, .wr, .a, .wd, .rdat, .rv);
   task c(input logic [11:0] ad, input logic [31:0] e);
      logic v;
      i_host.r(ad, d, v);
      n_compared++;
      if (d !== e || v !== 1'b1)
      begin
         n_mismatch++;
         $display("BAD %0t read %h got %h valid %b", $time, ad, d, v);
      end
   endtask : c
   task t_hdr;
      i_host.w(12'h100, '1);
      c(12'h100, 32'h0001_0001);
      en <= 1;
      c(12'h100, 32'h1501_0001);
      en <= 0;
      i_host.w(12'h14C, '1);
      c(12'h14C, 32'h0);
   endtask : t_hdr
   // hot, link, global, then power-on reset over refilled words
   task t_cls;
      for (int k = 0; k < 4; k++)
      begin
         i_host.w(12'h104, '1);
         i_host.w(12'h108, '1);
         i_host.w(12'h10C, '1);
         @(posedge clk) {srst, gr, lr, hr} <= 4'b0001 << k;
         @(posedge clk) {srst, gr, lr, hr} <= 4'b0000;
         c(12'h104, {32{k < 2}});
         c(12'h108, {32{k < 1}});
         c(12'h10C, 32'h0);
      end
   endtask : t_cls
   task tally_and_finish;
      $display("compared %0d mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : tally_and_finish
   initial
   begin
      repeat (12) @(posedge clk);
      srst <= 0;
      t_hdr();
      t_cls();
      tally_and_finish();
   end
   initial
   begin
      #20000;
      n_mismatch++;
      tally_and_finish();
   end
endmodule : tb
`default_nettype wire
